// ===== verilog/acp_pkg.sv
package acp_pkg;

    // register map, byte offsets on the plain register port
    localparam int unsigned ADDR_W            = 4;
    localparam logic [3:0]  OFF_CONFIG        = 4'h0;
    localparam logic [3:0]  OFF_PIN_LOW       = 4'h4;
    localparam logic [3:0]  OFF_PIN_MID       = 4'h8;
    localparam logic [3:0]  OFF_STATUS        = 4'hC;

    // configuration field positions
    localparam int unsigned LOW_POWER_BIT     = 7;
    localparam int unsigned DIV_HI            = 6;
    localparam int unsigned DIV_LO            = 5;
    localparam int unsigned LONG_SAMPLE_BIT   = 4;
    localparam int unsigned MODE_HI           = 3;
    localparam int unsigned MODE_LO           = 2;
    localparam int unsigned SRC_HI            = 1;
    localparam int unsigned SRC_LO            = 0;

    // reset values
    localparam logic [7:0]  CONFIG_RST        = 8'h00;
    localparam logic [7:0]  PIN_RST           = 8'h00;

    // resolution encodings
    localparam logic [1:0]  MODE_8BIT         = 2'h0;
    localparam logic [1:0]  MODE_10BIT        = 2'h2;

    // divider counter width: holds the largest count, 7, for divide by 8
    localparam int unsigned DIV_CNT_W         = 3;

    // channels per pin-control register
    localparam int unsigned PINS_PER_REG      = 8;
    localparam int unsigned NUM_PINS          = 16;

    // status bits
    localparam int unsigned STAT_MODE_OK_BIT  = 0;
    localparam int unsigned STAT_INVAL_BIT    = 1;
    localparam int unsigned STAT_CLK_BIT      = 2;

    typedef enum logic [1:0] {
        SRC_BUS,
        SRC_BUS_HALF,
        SRC_ALT,
        SRC_ASYNC
    } acp_src_e;

    typedef enum logic [1:0] {
        DIV_BY1,
        DIV_BY2,
        DIV_BY4,
        DIV_BY8
    } acp_div_e;

    typedef struct packed {
        logic       low_power_select;
        acp_div_e   clock_divide_select;
        logic       long_sample_select;
        logic [1:0] conversion_mode;
        acp_src_e   clock_source_select;
    } acp_cfg_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } acp_bus_s;

endpackage

// ===== verilog/acp_clk_div.sv
`timescale 1ns/1ns
// converter clock: source mux, one divider, clean switch on reprogramming
module acp_clk_div (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire acp_pkg::acp_src_e src_sel,
    input  wire acp_pkg::acp_div_e div_sel,
    input  wire logic             alt_en,
    input  wire logic             async_en,
    input  wire logic             restart,
    output logic                  conv_tick,
    output logic                  conv_clk_q
);

    logic                          half_q;
    logic                          src_tick;
    logic [acp_pkg::DIV_CNT_W-1:0] cnt_q;
    logic [acp_pkg::DIV_CNT_W-1:0] cnt_d;
    logic [acp_pkg::DIV_CNT_W-1:0] cnt_max;
    logic                          wrap;

    ////////////////////////////////////////////////////////////////////////
    // source multiplexer
    assign src_tick = (src_sel == acp_pkg::SRC_BUS)      ? 1'b1     :
                      (src_sel == acp_pkg::SRC_BUS_HALF) ? half_q   :
                      (src_sel == acp_pkg::SRC_ALT)      ? alt_en   :
                                                           async_en;

    // divide ratio minus one
    assign cnt_max = (div_sel == acp_pkg::DIV_BY1) ? 3'h0 :
                     (div_sel == acp_pkg::DIV_BY2) ? 3'h1 :
                     (div_sel == acp_pkg::DIV_BY4) ? 3'h3 :
                                                     3'h7;
    assign wrap  = src_tick && (cnt_q >= cnt_max);
    assign cnt_d = wrap ? 3'h0 : cnt_q + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            half_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
        end
    end

    // restart drops count and output low so no runt pulse follows a change
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cnt_q      <= 3'h0;
            conv_tick  <= 1'b0;
            conv_clk_q <= 1'b0;
        end else begin
            conv_tick <= wrap;
            if (src_tick) begin
                cnt_q <= cnt_d;
            end
            if (wrap) begin
                conv_clk_q <= ~conv_clk_q;
            end
        end
    end

endmodule

// ===== verilog/acp_top.sv
`timescale 1ns/1ns
// Summary of operation
// - configuration bit 7 picks high speed (0) or low power (1) mode.
// - bits 6:5 divide the chosen clock by 1, 2, 4 or 8.
// - bit 4 picks short (0) or long (1) sample time.
// - bits 3:2 pick 8-bit (00) or 10-bit (10) conversion; 01, 11 reserved.
// - bits 1:0 pick bus, bus/2, alternate or converter async clock.
// - low pin register bit n disables port control of channel n, 0..7.
// - mid pin register bit n disables port control of channel n+8.
// - a pin bit of 0 keeps port control, 1 hands the pin to the converter.
// - low power mode cuts power and lowers the allowed converter clock.
// - a disabled pin floats its output, kills input and pullup, reads 0.
// - the clock source resets to the bus clock encoding.
// - a change of resolution marks any held result invalid.
module acp_top (
    input  wire logic        CORE_CLK,
    input  wire logic        SRST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic        ALT_CLK_PIN,
    input  wire logic        ASYNC_CLK_PIN,
    input  wire logic        RESULT_LOADED,
    input  wire logic [15:0] PORT_OUT_EN,
    input  wire logic [15:0] PORT_PULLUP_EN,
    input  wire logic [15:0] PORT_PIN_IN,
    output logic             CONVERTER_CLOCK,
    output logic             CONVERTER_TICK,
    output logic             LOW_POWER,
    output logic             LONG_SAMPLE,
    output logic             MODE_10BIT,
    output logic             RESULT_INVALID,
    output logic [15:0]      PIN_DISABLE,
    output logic [15:0]      PIN_OUT_EN,
    output logic [15:0]      PIN_PULLUP_EN,
    output logic [15:0]      PIN_READ
);

    ////////////////////////////////////////////////////////////////////////
    // bus capture and decode
    acp_pkg::acp_bus_s bus;
    logic              hit_cfg;
    logic              hit_low;
    logic              hit_mid;
    logic              hit_stat;
    logic              wr_cfg;
    logic              wr_low;
    logic              wr_mid;

    assign bus.addr  = ADDR;
    assign bus.wdata = WDATA;
    assign bus.wr    = WR;
    assign bus.rd    = RD;

    assign hit_cfg  = (bus.addr == acp_pkg::OFF_CONFIG);
    assign hit_low  = (bus.addr == acp_pkg::OFF_PIN_LOW);
    assign hit_mid  = (bus.addr == acp_pkg::OFF_PIN_MID);
    assign hit_stat = (bus.addr == acp_pkg::OFF_STATUS);
    assign wr_cfg   = bus.wr && hit_cfg;
    assign wr_low   = bus.wr && hit_low;
    assign wr_mid   = bus.wr && hit_mid;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]        cfg_q;
    logic [7:0]        pin_low_q;
    logic [7:0]        pin_mid_q;
    acp_pkg::acp_cfg_s cfg;
    logic              mode_change;
    logic              invalid_q;
    logic              invalid_d;
    logic              restart;

    assign cfg = acp_pkg::acp_cfg_s'(cfg_q);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cfg_q     <= acp_pkg::CONFIG_RST;
            pin_low_q <= acp_pkg::PIN_RST;
            pin_mid_q <= acp_pkg::PIN_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= bus.wdata;
            end
            if (wr_low) begin
                pin_low_q <= bus.wdata;
            end
            if (wr_mid) begin
                pin_mid_q <= bus.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result invalidation on resolution change
    assign mode_change = wr_cfg
        && (bus.wdata[acp_pkg::MODE_HI:acp_pkg::MODE_LO]
            != cfg_q[acp_pkg::MODE_HI:acp_pkg::MODE_LO]);
    // change wins over a new result in the same cycle
    assign invalid_d = mode_change ? 1'b1 :
                       RESULT_LOADED ? 1'b0 : invalid_q;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            invalid_q <= 1'b0;
        end else begin
            invalid_q <= invalid_d;
        end
    end

    // divider restarts when a config write changes the source or divide field
    assign restart = wr_cfg
        && (bus.wdata[acp_pkg::DIV_HI:acp_pkg::SRC_LO]
            != cfg_q[acp_pkg::DIV_HI:acp_pkg::SRC_LO]
            || bus.wdata[acp_pkg::MODE_HI:acp_pkg::MODE_LO]
            != cfg_q[acp_pkg::MODE_HI:acp_pkg::MODE_LO])
        && (bus.wdata[acp_pkg::DIV_HI:acp_pkg::DIV_LO]
            != cfg_q[acp_pkg::DIV_HI:acp_pkg::DIV_LO]
            || bus.wdata[acp_pkg::SRC_HI:acp_pkg::SRC_LO]
            != cfg_q[acp_pkg::SRC_HI:acp_pkg::SRC_LO]);

    ////////////////////////////////////////////////////////////////////////
    // external clock pins: two-stage sync, then rising-edge enable
    logic [1:0] alt_sync_q;
    logic [1:0] async_sync_q;
    logic       alt_last_q;
    logic       async_last_q;
    logic       alt_en;
    logic       async_en;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            alt_sync_q   <= 2'h0;
            async_sync_q <= 2'h0;
            alt_last_q   <= 1'b0;
            async_last_q <= 1'b0;
        end else begin
            alt_sync_q   <= {alt_sync_q[0], ALT_CLK_PIN};
            async_sync_q <= {async_sync_q[0], ASYNC_CLK_PIN};
            alt_last_q   <= alt_sync_q[1];
            async_last_q <= async_sync_q[1];
        end
    end

    assign alt_en   = alt_sync_q[1] && !alt_last_q;
    assign async_en = async_sync_q[1] && !async_last_q;

    ////////////////////////////////////////////////////////////////////////
    // converter clock generation
    logic conv_clk;
    logic conv_tick;

    acp_clk_div u_div (
        .clk        (CORE_CLK),
        .rst        (SRST),
        .src_sel    (cfg.clock_source_select),
        .div_sel    (cfg.clock_divide_select),
        .alt_en     (alt_en),
        .async_en   (async_en),
        .restart    (restart),
        .conv_tick  (conv_tick),
        .conv_clk_q (conv_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin control, one slice per channel
    logic [15:0] disable_w;
    logic [15:0] out_en_d;
    logic [15:0] pullup_d;
    logic [15:0] read_d;

    assign disable_w = {pin_mid_q, pin_low_q};

    for (genvar i = 0; i < acp_pkg::NUM_PINS; i++) begin : g_pin
        assign out_en_d[i] = disable_w[i] ? 1'b0 : PORT_OUT_EN[i];
        assign pullup_d[i] = disable_w[i] ? 1'b0 : PORT_PULLUP_EN[i];
        assign read_d[i]   = disable_w[i] ? 1'b0 : PORT_PIN_IN[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] status_w;
    logic [7:0] rdata_d;
    logic       mode_ok;

    // reserved resolution encodings are flagged, not honoured
    assign mode_ok = (cfg.conversion_mode == acp_pkg::MODE_8BIT)
                  || (cfg.conversion_mode == acp_pkg::MODE_10BIT);

    assign status_w = {5'h00, conv_clk, invalid_q, mode_ok};

    assign rdata_d = !bus.rd  ? 8'h00     :
                     hit_cfg  ? cfg_q     :
                     hit_low  ? pin_low_q :
                     hit_mid  ? pin_mid_q :
                     hit_stat ? status_w  : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RDATA           <= 8'h00;
            CONVERTER_CLOCK <= 1'b0;
            CONVERTER_TICK  <= 1'b0;
            LOW_POWER       <= 1'b0;
            LONG_SAMPLE     <= 1'b0;
            MODE_10BIT      <= 1'b0;
            RESULT_INVALID  <= 1'b0;
            PIN_DISABLE     <= 16'h0000;
            PIN_OUT_EN      <= 16'h0000;
            PIN_PULLUP_EN   <= 16'h0000;
            PIN_READ        <= 16'h0000;
        end else begin
            RDATA           <= rdata_d;
            CONVERTER_CLOCK <= conv_clk;
            CONVERTER_TICK  <= conv_tick;
            LOW_POWER       <= cfg.low_power_select;
            LONG_SAMPLE     <= cfg.long_sample_select;
            MODE_10BIT      <= (cfg.conversion_mode
                                == acp_pkg::MODE_10BIT);
            RESULT_INVALID  <= invalid_q;
            PIN_DISABLE     <= disable_w;
            PIN_OUT_EN      <= out_en_d;
            PIN_PULLUP_EN   <= pullup_d;
            PIN_READ        <= read_d;
        end
    end

endmodule

// ===== dv/acp_top_asserts.sv
`timescale 1ns/1ns
module acp_chk (
    input wire logic        CORE_CLK,
    input wire logic        SRST,
    input wire logic [3:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        RESULT_LOADED,
    input wire logic [15:0] PORT_OUT_EN,
    input wire logic [15:0] PORT_PIN_IN,
    input wire logic        LOW_POWER,
    input wire logic        LONG_SAMPLE,
    input wire logic        MODE_10BIT,
    input wire logic        RESULT_INVALID,
    input wire logic [15:0] PIN_DISABLE,
    input wire logic [15:0] PIN_OUT_EN,
    input wire logic [15:0] PIN_READ,
    input wire logic        CONVERTER_CLOCK,
    input wire logic        CONVERTER_TICK
);
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);
    sequence cfg_wr;
        WR && ADDR == acp_pkg::OFF_CONFIG;
    endsequence
    sequence low_wr;
        WR && ADDR == acp_pkg::OFF_PIN_LOW;
    endsequence
    sequence mid_wr;
        WR && ADDR == acp_pkg::OFF_PIN_MID;
    endsequence
    // pin mask settled for two samples
    sequence pins_held;
        $stable(PIN_DISABLE) [*2];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not idle");
    low_power_a: assert property (cfg_wr |->
        ##2 LOW_POWER == $past(WDATA[7], 2))
        else $error("low power level wrong");
    long_sample_a: assert property (cfg_wr |->
        ##2 LONG_SAMPLE == $past(WDATA[4], 2))
        else $error("long sample level wrong");
    mode_cfg_a: assert property (cfg_wr and !WDATA[2] |->
        ##2 MODE_10BIT == $past(WDATA[3], 2))
        else $error("resolution level wrong");
    low_pins_a: assert property (low_wr |->
        ##2 PIN_DISABLE[7:0] == $past(WDATA, 2))
        else $error("low pin mask wrong");
    mid_pins_a: assert property (mid_wr |->
        ##2 PIN_DISABLE[15:8] == $past(WDATA, 2))
        else $error("mid pin mask wrong");
    oe_forced_a: assert property (pins_held |->
        PIN_OUT_EN == ($past(PORT_OUT_EN) & ~PIN_DISABLE))
        else $error("output enable not forced");
    read_forced_a: assert property (pins_held |->
        PIN_READ == ($past(PORT_PIN_IN) & ~PIN_DISABLE))
        else $error("pin read not forced");
    reset_clear_a: assert property ($past(SRST) |->
        !LOW_POWER && !MODE_10BIT && PIN_DISABLE == 16'h0000)
        else $error("state not cleared by reset");
    inval_set_a: assert property (
        $changed(MODE_10BIT) && !$past(RESULT_LOADED) |-> RESULT_INVALID)
        else $error("mode change left result valid");
    // flag clears at the load edge, output flop shows it one edge later
    load_clear_a: assert property (RESULT_LOADED && !WR |->
        ##2 !RESULT_INVALID)
        else $error("new result left invalid flag");
    tick_toggle_a: assert property (CONVERTER_TICK |->
        $changed(CONVERTER_CLOCK))
        else $error("converter tick without clock edge");
endmodule
bind acp_top acp_chk u_chk (.*);

// ===== dv/test_adc_config_pin_control.sv
`timescale 1ns/1ns
module test_adc_config_pin_control;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        alt = 1'b0;
    logic        asy = 1'b0;
    logic        loaded = 1'b0;
    logic [15:0] p_oe = 16'h0000;
    logic [15:0] p_pu = 16'h0000;
    logic [15:0] p_in = 16'h0000;
    logic [7:0]  rdata;
    logic        cclk;
    logic        lp;
    logic        ls;
    logic        m10;
    logic        inval;
    logic [15:0] pdis;
    logic [15:0] poe;
    logic [15:0] ppu;
    logic [15:0] prd;
    int          n_fail = 0;
    int          n_checks = 0;
    int          acnt = 0;
    always #2 clk = ~clk;
    // alternate source rises every 6 cycles, async source every 10
    always @(posedge clk) begin
        acnt <= acnt + 1;
        if (acnt % 3 == 2) alt <= ~alt;
        if (acnt % 5 == 4) asy <= ~asy;
    end
    acp_top dut (.CORE_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .ALT_CLK_PIN(alt),
        .ASYNC_CLK_PIN(asy), .RESULT_LOADED(loaded), .PORT_OUT_EN(p_oe),
        .PORT_PULLUP_EN(p_pu), .PORT_PIN_IN(p_in), .CONVERTER_CLOCK(cclk),
        .CONVERTER_TICK(), .LOW_POWER(lp), .LONG_SAMPLE(ls),
        .MODE_10BIT(m10), .RESULT_INVALID(inval), .PIN_DISABLE(pdis),
        .PIN_OUT_EN(poe), .PIN_PULLUP_EN(ppu), .PIN_READ(prd));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, {8'h00, rdata}, {8'h00, e});
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wait_rise(output int n);
        logic prv;
        n = 0;
        do begin
            prv = cclk;
            @(posedge clk);
            #1;
            n++;
        end while (!(cclk && !prv) && n < 500);
        if (n >= 500) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd_chk("cfg", acp_pkg::OFF_CONFIG, 8'h00);
        rd_chk("low", acp_pkg::OFF_PIN_LOW, 8'h00);
        rd_chk("mid", acp_pkg::OFF_PIN_MID, 8'h00);
        chk("pdis", pdis, 16'h0000);
    endtask
    task automatic s_cfg;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 8'h55 * i[7:0];
            wr_reg(acp_pkg::OFF_CONFIG, v);
            rd_chk("cfg", acp_pkg::OFF_CONFIG, v);
            chk("lp", 16'(lp), 16'(v[7]));
            chk("ls", 16'(ls), 16'(v[4]));
            if (!v[2]) chk("m10", 16'(m10), 16'(v[3]));
        end
    endtask
    task automatic s_clk;
        int n;
        int f[4] = '{1, 2, 6, 10};
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                wr_reg(acp_pkg::OFF_CONFIG, {1'b0, d[1:0], 3'b000, s[1:0]});
                wait_rise(n);
                wait_rise(n);
                wait_rise(n);
                chk("period", 16'(n), 16'((2 * f[s]) << d));
            end
        end
    endtask
    task automatic s_pins;
        logic [15:0] m;
        p_oe <= 16'hFFFF;
        p_pu <= 16'hFFFF;
        p_in <= 16'hFFFF;
        for (int i = 0; i < 16; i++) begin
            m = 16'h0001 << i;
            wr_reg(acp_pkg::OFF_PIN_LOW, m[7:0]);
            wr_reg(acp_pkg::OFF_PIN_MID, m[15:8]);
            settle();
            chk("pdis", pdis, m);
            chk("oe", poe, ~m);
            chk("pu", ppu, ~m);
            chk("rd", prd, ~m);
        end
        p_in <= 16'h5AA5;
        settle();
        chk("rd2", prd, 16'h5AA5 & ~m);
        wr_reg(4'h2, 8'hFF);
        wr_reg(acp_pkg::OFF_STATUS, 8'hFF);
        rd_chk("unmapped", 4'h2, 8'h00);
        rd_chk("mid", acp_pkg::OFF_PIN_MID, 8'h80);
        rd_chk("low", acp_pkg::OFF_PIN_LOW, 8'h00);
    endtask
    task automatic s_inval;
        wr_reg(acp_pkg::OFF_CONFIG, 8'h00);
        @(posedge clk);
        loaded <= 1'b1;
        @(posedge clk);
        loaded <= 1'b0;
        settle();
        chk("inval", 16'(inval), 16'h0000);
        wr_reg(acp_pkg::OFF_CONFIG, 8'h10);
        settle();
        chk("inval", 16'(inval), 16'h0000);
        wr_reg(acp_pkg::OFF_CONFIG, 8'h08);
        settle();
        chk("inval", 16'(inval), 16'h0001);
        // reserved mode, slow async source: clock bit held low by restart
        wr_reg(acp_pkg::OFF_CONFIG, 8'h67);
        rd_chk("stat", acp_pkg::OFF_STATUS, 8'h02);
        chk("m10", 16'(m10), 16'h0000);
        // mode change and new result in one cycle: set wins
        @(posedge clk);
        addr <= acp_pkg::OFF_CONFIG;
        wdata <= 8'h08;
        wr <= 1'b1;
        loaded <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        loaded <= 1'b0;
        settle();
        chk("inval", 16'(inval), 16'h0001);
    endtask
    initial begin
        s_reset();
        s_cfg();
        s_clk();
        s_pins();
        s_inval();
        s_reset();
        tally_and_finish();
    end
endmodule
